/* File: verification/fsp_cpu_model.sv */
// Processor core model issuing store and load program instructions
`timescale 1ns/1ps
module fsp_cpu_model (
  input wire logic clk, // System clock
  input wire logic loadValid, // Special load served
  input wire logic [7:0] loadData, // Special load result
  output logic storeInstr, // Store instruction strobe
  output logic loadInstr, // Load instruction strobe
  output logic [15:0] pointer, // Address pointer
  output logic [15:0] dataPair, // Word data for page load
  output logic eepromWriteBusy, // EEPROM write in progress
  output logic selfprogFuse // Zero enables store
);
  initial
  begin
    storeInstr = 1'b0;
    loadInstr = 1'b0;
    pointer = 16'h0000;
    dataPair = 16'h0000;
    eepromWriteBusy = 1'b0;
    selfprogFuse = 1'b0;
  end
  // Called one idle edge after the arming edge; operands turn over once the edge has taken them
  task automatic store(input logic [15:0] ptr, input logic [15:0] dat);
    pointer <= ptr;
    dataPair <= dat;
    storeInstr <= 1'b1;
    @(posedge clk);
    storeInstr <= 1'b0;
    pointer <= ~ptr;
    dataPair <= ~dat;
  endtask : store
  task automatic load(input logic [15:0] ptr, output logic [7:0] v, output logic ok);
    pointer <= ptr;
    loadInstr <= 1'b1;
    @(posedge clk);
    loadInstr <= 1'b0;
    pointer <= ~ptr;
    @(posedge clk);
    v = loadData;
    ok = loadValid;
  endtask : load
endmodule : fsp_cpu_model

/* File: verification/test_flash_self_program_ctrl.sv */
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ps
`include "fsp_map.svh"
module test_flash_self_program_ctrl;
  localparam int PROG = 20;
  localparam logic [11:0] CTRL = `FSP_CTRL_ADDR;
  localparam logic [7:0] SIG = 8'h3C; // Arbitrary
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, se, sl, sp, sf, sb, sg, loadValid, cpuHalt, flashWe, flashErase, ok;
  logic [15:0] sptr, sdat;
  logic [7:0] loadData, v;
  logic [10:0] flashPage;
  logic [511:0] flashData;
  int errCount = 0, nChecks = 0;
  always #12.5 clk = ~clk;
  fsp_flash_self_program_ctrl #(.PROG_CYCLES(PROG), .FUSE_LOW(8'h12), .FUSE_HIGH(8'hD7),
    .FUSE_EXT(8'hFE), .LOCK_BITS(8'hFC), .SIG_SEED(SIG)) dut (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .storeInstr(sl), .loadInstr(sg),
    .pointer(sptr), .dataPair(sdat), .eepromWriteBusy(sb), .selfprogFuse(sf),
    .loadData(loadData), .loadValid(loadValid), .cpuHalt(cpuHalt), .flashWe(flashWe),
    .flashErase(flashErase), .flashPage(flashPage), .flashData(flashData));
  fsp_cpu_model cpu (.clk(clk), .loadValid(loadValid), .loadData(loadData), .storeInstr(sl),
    .loadInstr(sg), .pointer(sptr), .dataPair(sdat), .eepromWriteBusy(sb), .selfprogFuse(sf));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    nChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so that a following call never reassigns psel in this step
    @(posedge clk);
  endtask : apb
  // Erase or write, counting halted cycles up to the completion pulse
  task automatic prog_op(input logic [7:0] cmd, input logic [15:0] ptr);
    int n = 0;
    int k = 0;
    apb(1'b1, CTRL, {24'h0, cmd});
    cpu.store(ptr, 16'hA5A5);
    do
    begin
      @(posedge clk);
      n += (cpuHalt === 1'b1);
      k++;
    end
    while (flashWe !== 1'b1 && flashErase !== 1'b1 && k < 3 * PROG);
    check({31'h0, n >= PROG && n <= PROG * 45 / 37}, 32'h1, "halt span");
    check({31'h0, flashErase}, {31'h0, cmd == 8'h03}, "pulse kind");
    check({21'h0, flashPage}, {21'h0, ptr[15:5]}, "page");
    apb(1'b0, CTRL, 32'h0);
    check(q, 32'h0, "ctrl after op");
  endtask : prog_op
  // Arm, then miss the window or find the store blocked: no halt may follow
  task automatic late_store(input int gap);
    apb(1'b1, CTRL, 32'h05);
    repeat (gap) @(posedge clk);
    cpu.store(16'h0040, 16'h0);
    @(posedge clk);
    check({31'h0, cpuHalt}, 32'h0, "ignored store");
    repeat (5) @(posedge clk);
    apb(1'b0, CTRL, 32'h0);
    check(q, 32'h0, "ctrl timeout");
  endtask : late_store
  task automatic wrapUp();
    if (errCount == 0 && nChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrapUp
  initial
  begin
    #(25 * 4000);
    errCount++;
    wrapUp();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    apb(1'b1, CTRL, 32'hC0);
    apb(1'b0, CTRL, 32'h0);
    check(q, 32'h0, "reserved bits");
    apb(1'b0, 12'h0FC, 32'h0);
    check({31'h0, se}, 32'h1, "unmapped");
    apb(1'b1, CTRL, 32'h01);
    cpu.store(16'h0005, 16'h1234);
    repeat (2) @(posedge clk);
    check({16'h0, flashData[32 +: 16]}, 32'h1234, "loaded word");
    apb(1'b1, CTRL, 32'h10);
    repeat (2) @(posedge clk);
    check({16'h0, flashData[32 +: 16]}, 32'hFFFF, "cleared word");
    apb(1'b1, CTRL, 32'h01);
    cpu.store(16'h0007, 16'hBEEF);
    cpu.eepromWriteBusy <= 1'b1;
    repeat (3) @(posedge clk);
    check({16'h0, flashData[48 +: 16]}, 32'hFFFF, "eeprom discard");
    apb(1'b1, CTRL, 32'h01);
    apb(1'b0, CTRL, 32'h0);
    check(q, 32'h0, "blocked arm");
    cpu.eepromWriteBusy <= 1'b0;
    apb(1'b1, CTRL, 32'h01);
    cpu.store(16'h0000, 16'h5AA5);
    prog_op(8'h05, 16'h0040);
    check({31'h0, flashData === {512{1'b1}}}, 32'h1, "buffer after write");
    prog_op(8'h03, 16'h006B);
    late_store(4);
    cpu.selfprogFuse <= 1'b1;
    late_store(0);
    cpu.selfprogFuse <= 1'b0;
    foreach (sptr[i])
    begin
      if (i < 4)
      begin
        apb(1'b1, CTRL, 32'h09);
        cpu.load(16'(i), v, ok);
        check({23'h0, ok, v}, {23'h0, 1'b1, 8'(32'h12FCFED7 >> (8 * (3 - i)))}, "fuse");
      end
    end
    apb(1'b0, CTRL, 32'h0);
    check(q, 32'h0, "select cleared");
    apb(1'b1, CTRL, 32'h21);
    cpu.load(16'h0001, v, ok);
    check({23'h0, ok, v}, {23'h0, 1'b1, SIG ^ 8'h01}, "signature");
    apb(1'b1, CTRL, 32'h09);
    repeat (3) @(posedge clk);
    cpu.load(16'h0001, v, ok);
    check({31'h0, ok}, 32'h0, "late load");
    wrapUp();
  end
endmodule : test_flash_self_program_ctrl

/* File: verilog/fsp_flash_self_program_ctrl.sv */
// Flash self-programming sequencer with APB control/status access
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "fsp_map.svh"
module fsp_flash_self_program_ctrl
  import fsp_pkg::*;
#(
  parameter int WORD_BITS = 5,
  parameter int SIG_DEPTH = 4,
  parameter int PROG_CYCLES = (`FSP_PROG_MIN_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS,
  parameter logic [7:0] FUSE_LOW = 8'h62,
  parameter logic [7:0] FUSE_HIGH = 8'hDF,
  parameter logic [7:0] FUSE_EXT = 8'hFF,
  parameter logic [7:0] LOCK_BITS = 8'hFF,
  parameter logic [7:0] SIG_SEED = 8'h5A // Arbitrary signature seed
)(
  input wire logic clk, // System clock, 40 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic storeInstr, // Store program instruction strobe
  input wire logic loadInstr, // Load program instruction strobe
  input wire logic [15:0] pointer, // Address pointer
  input wire logic [15:0] dataPair, // Word data for page load
  input wire logic eepromWriteBusy, // EEPROM write in progress
  input wire logic selfprogFuse, // Self-program fuse, 0 = enabled
  output logic [7:0] loadData, // Load instruction result byte
  output logic loadValid, // Special load served, one cycle
  output logic cpuHalt, // Processor halt request
  output logic flashWe, // Flash page program pulse
  output logic flashErase, // Flash page erase pulse
  output logic [15-WORD_BITS:0] flashPage, // Page under program or erase
  output logic [16*(1<<WORD_BITS)-1:0] flashData // Page buffer contents
);
  localparam int NWORDS = 1 << WORD_BITS;
  localparam int PMAX = `FSP_PROG_MAX_NS / `FSP_CLK_NS;

  // ----------------------------------------------------------------
  // Registers and buffer
  // ----------------------------------------------------------------
  logic [5:0] ctrl;
  logic [2:0] winCnt;
  logic [22:0] progCnt;
  fsp_state_t state;
  fsp_op_t op;
  logic [15:0] pageBuf [NWORDS];
  logic [NWORDS-1:0] bufValid;

  function automatic logic [7:0] sig_byte(input logic [15:0] idx);
    sig_byte = SIG_SEED ^ idx[7:0];
  endfunction : sig_byte

  wire apbWr = psel && penable && pwrite;
  wire ctrlWr = apbWr && (paddr == `FSP_CTRL_ADDR) && !eepromWriteBusy;
  wire armed = state == FSP_ARMED;
  wire storeOk = armed && storeInstr && !selfprogFuse && winCnt != 3'h0;
  wire loadOk = armed && loadInstr && winCnt != 3'h0
                && (ctrl[`FSP_BIT_FUSE_RD] || ctrl[`FSP_BIT_SIG_RD]);
  wire progDone = state == FSP_PROG && progCnt == 23'h0;
  wire clrBuf = (ctrlWr && pwdata[`FSP_BIT_CLR_BUF])
                || (progDone && op == FSP_OP_WRITE)
                || (eepromWriteBusy && |bufValid);

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable)
      begin
        if (paddr == `FSP_CTRL_ADDR)
          prdata <= {26'h0, ctrl};
        else if (paddr == `FSP_STATUS_ADDR)
          prdata <= {30'h0, state};
        else
          pslverr <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register and sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl <= 6'h00;
      state <= FSP_IDLE;
      op <= FSP_OP_LOAD;
      winCnt <= 3'h0;
      progCnt <= 23'h0;
      cpuHalt <= 1'b0;
      flashPage <= '0;
    end
    else
    begin
      case (state)
        FSP_IDLE, FSP_ARMED:
        begin
          if (ctrlWr)
          begin
            ctrl <= {pwdata[5], 1'b0, pwdata[3:0]};
            winCnt <= pwdata[`FSP_BIT_FUSE_RD] || pwdata[`FSP_BIT_SIG_RD]
                      ? `FSP_LOAD_WINDOW : `FSP_STORE_WINDOW;
            state <= pwdata[`FSP_BIT_STORE_EN] ? FSP_ARMED : FSP_IDLE;
          end
          else if (loadOk)
          begin
            ctrl <= 6'h00;
            state <= FSP_IDLE;
          end
          else if (storeOk && (ctrl[`FSP_BIT_ERASE] || ctrl[`FSP_BIT_WRITE]))
          begin
            op <= ctrl[`FSP_BIT_WRITE] ? FSP_OP_WRITE : FSP_OP_ERASE;
            flashPage <= pointer[15:WORD_BITS];
            progCnt <= 23'(PROG_CYCLES - 1);
            cpuHalt <= 1'b1;
            state <= FSP_PROG;
          end
          else if (storeOk || (armed && winCnt == 3'h1))
          begin
            ctrl <= 6'h00;
            state <= FSP_IDLE;
          end
          else if (armed)
            winCnt <= winCnt - 3'h1;
        end
        FSP_PROG:
        begin
          if (progDone)
          begin
            ctrl <= 6'h00;
            cpuHalt <= 1'b0;
            state <= FSP_IDLE;
          end
          else
            progCnt <= progCnt - 23'h1;
        end
        default: state <= FSP_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Page buffer
  // ----------------------------------------------------------------
  // Buffer words are not reset individually; the valid mask makes them read as erased.
  always_ff @(posedge clk)
  begin
    if (storeOk && ctrl[3:1] == 3'b000)
      pageBuf[pointer[WORD_BITS:1]] <= dataPair;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      bufValid <= '0;
    else if (clrBuf)
      bufValid <= '0;
    else if (storeOk && ctrl[3:1] == 3'b000)
      bufValid[pointer[WORD_BITS:1]] <= 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flashWe <= 1'b0;
      flashErase <= 1'b0;
      flashData <= '0;
    end
    else
    begin
      flashWe <= progDone && op == FSP_OP_WRITE;
      flashErase <= progDone && op == FSP_OP_ERASE;
      for (int i = 0; i < NWORDS; i++)
        flashData[16*i +: 16] <= bufValid[i] ? pageBuf[i] : 16'hFFFF;
    end
  end

  // ----------------------------------------------------------------
  // Load instruction results
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      loadData <= 8'h00;
      loadValid <= 1'b0;
    end
    else
    begin
      loadValid <= loadOk;
      if (loadOk && ctrl[`FSP_BIT_SIG_RD])
        loadData <= sig_byte(pointer);
      else if (loadOk)
      begin
        // Stored fuse values are already active-low: programmed reads zero
        if (pointer == `FSP_PTR_LOCK)
          loadData <= LOCK_BITS;
        else if (pointer == `FSP_PTR_FUSE_LOW)
          loadData <= FUSE_LOW;
        else if (pointer == `FSP_PTR_FUSE_EXT)
          loadData <= FUSE_EXT;
        else if (pointer == `FSP_PTR_FUSE_HIGH)
          loadData <= FUSE_HIGH;
        else
          loadData <= 8'hFF;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_halt_during_prog: assert property (@(posedge clk) disable iff (!arst_n)
    state == FSP_PROG |-> cpuHalt) else $error("cpu not halted");
  a_window_expiry: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(armed) && !storeInstr && !loadInstr && !ctrlWr
    ##1 (!storeInstr && !loadInstr && !ctrlWr) [*3] |=> !armed)
    else $error("window overrun");
  a_prog_length: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(cpuHalt) |-> cpuHalt [*8]) else $error("program too short");
  a_prog_bound: assert property (@(posedge clk) disable iff (!arst_n)
    progCnt <= 23'(PMAX)) else $error("program too long");
  a_eeprom_block: assert property (@(posedge clk) disable iff (!arst_n)
    eepromWriteBusy && apbWr && state == FSP_IDLE |=> state == FSP_IDLE)
    else $error("armed under eeprom");
  a_clear_buf: assert property (@(posedge clk) disable iff (!arst_n)
    clrBuf |=> bufValid == '0) else $error("buffer not cleared");
  a_fuse_gate: assert property (@(posedge clk) disable iff (!arst_n)
    storeInstr && selfprogFuse |=> !cpuHalt || $past(cpuHalt))
    else $error("store ran with fuse off");
  a_read_clears: assert property (@(posedge clk) disable iff (!arst_n)
    loadOk |=> ctrl == 6'h00 && loadValid) else $error("read not cleared");
  a_write_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    progDone && op == FSP_OP_WRITE |=> flashWe && !cpuHalt)
    else $error("write not finished");
  c_page_write: cover property (@(posedge clk) flashWe);
  c_page_erase: cover property (@(posedge clk) flashErase);
  c_fuse_read: cover property (@(posedge clk) loadValid && !ctrl[5]);
  c_timeout: cover property (@(posedge clk) armed && winCnt == 3'h1 && !storeInstr);
endmodule : fsp_flash_self_program_ctrl

/* File: verilog/fsp_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH
`define FSP_CTRL_OFFSET 8'h37
`define FSP_CTRL_ADDR 12'h0DC
`define FSP_CTRL_RESET 8'h00
`define FSP_BIT_STORE_EN 0
`define FSP_BIT_ERASE 1
`define FSP_BIT_WRITE 2
`define FSP_BIT_FUSE_RD 3
`define FSP_BIT_CLR_BUF 4
`define FSP_BIT_SIG_RD 5
`define FSP_STATUS_ADDR 12'h100
`define FSP_STORE_WINDOW 3'h4
`define FSP_LOAD_WINDOW 3'h3
`define FSP_PROG_MIN_NS 3700000
`define FSP_PROG_MAX_NS 4500000
`define FSP_CLK_NS 25
`define FSP_PTR_LOCK 16'h0001
`define FSP_PTR_FUSE_LOW 16'h0000
`define FSP_PTR_FUSE_EXT 16'h0002
`define FSP_PTR_FUSE_HIGH 16'h0003
`endif

/* File: verilog/fsp_pkg.sv */
// Types for the flash self-programming sequencer
package fsp_pkg;
  typedef enum logic [1:0] {
    FSP_IDLE = 2'b00,
    FSP_ARMED = 2'b01,
    FSP_PROG = 2'b10
  } fsp_state_t;
  typedef enum logic [1:0] {
    FSP_OP_LOAD = 2'b00,
    FSP_OP_ERASE = 2'b01,
    FSP_OP_WRITE = 2'b10
  } fsp_op_t;
endpackage : fsp_pkg
